// file: design/homing_defs.vh
/*
  Constants for the home-switch homing sequencer: method codes,
  motion command encodings and latch edge selectors.
  Assumes a single 40 MHz clock and an include by bare name.
*/
`ifndef HOMING_DEFS_VH
`define HOMING_DEFS_VH

// Homing method codes handled here
`define HM_METHOD_W     8
`define HM_M19          8'h13
`define HM_M20          8'h14
`define HM_M21          8'h15
`define HM_M22          8'h16
`define HM_M23          8'h17
`define HM_M24          8'h18
`define HM_M25          8'h19

// Direction encoding on dir_fwd_o
`define HM_DIR_FWD      1'b1
`define HM_DIR_REV      1'b0

// Speed encoding on speed_high_o
`define HM_SPD_HIGH     1'b1
`define HM_SPD_LOW      1'b0

// Edge selector for the latch phase
`define HM_EDGE_RISE    1'b1
`define HM_EDGE_FALL    1'b0

`endif

// file: design/home_switch_homing_sequencer.v
/*
  Home-switch homing sequencer for methods 19 to 25. It picks motion
  phases from the switch level at start, the forward limit and the
  home switch edges, and latches the zero position on the chosen edge.
  Assumes switch inputs synchronous enough for a two-stage sampler,
  and an outside profile generator that follows run/dir/speed.
*/
`include "homing_defs.vh"

module home_switch_homing_sequencer (
  input  wire        mclk_i,
  input  wire        resetn_i,
  input  wire        start_i,
  input  wire [7:0]  method_i,
  input  wire        home_sw_i,
  input  wire        fwd_limit_i,
  input  wire [31:0] position_i,
  output reg         run_o,
  output reg         dir_fwd_o,
  output reg         speed_high_o,
  output reg         busy_o,
  output reg         done_o,
  output reg         error_o,
  output reg  [31:0] zero_pos_o
);

  // States: search phase waits on an edge, final phase latches on an edge
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_SEEK   = 3'd1;
  localparam [2:0] ST_MID    = 3'd2;
  localparam [2:0] ST_FINAL  = 3'd3;
  localparam [2:0] ST_DONE   = 3'd4;

  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [1:0] home_sync_r;
  reg  [1:0] lim_sync_r;
  reg        home_prev_r;
  reg        lim_prev_r;
  reg  [7:0] method_r;
  reg        start_on_r;
  reg        limit_hit_r;
  reg        seek_edge_r;
  reg        final_edge_r;
  reg        mid_used_r;

  wire home_s    = home_sync_r[1];
  wire lim_s     = lim_sync_r[1];
  wire home_rise = home_s & ~home_prev_r;
  wire home_fall = ~home_s & home_prev_r;
  wire lim_rise  = lim_s & ~lim_prev_r;

  // True when the selected method is in the supported range
  function method_ok;
    input [7:0] m;
    begin
      method_ok = (m >= `HM_M19) && (m <= `HM_M25);
    end
  endfunction

  // Picks the edge watched by the current phase
  function edge_hit;
    input sel;
    input rise;
    input fall;
    begin
      edge_hit = (sel == `HM_EDGE_RISE) ? rise : fall;
    end
  endfunction

  // Two-stage synchronisers and previous-sample registers
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      home_sync_r <= 2'b00;
      lim_sync_r  <= 2'b00;
      home_prev_r <= 1'b0;
      lim_prev_r  <= 1'b0;
    end
    else
    begin
      home_sync_r <= {home_sync_r[0], home_sw_i};
      lim_sync_r  <= {lim_sync_r[0], fwd_limit_i};
      home_prev_r <= home_s;
      lim_prev_r  <= lim_s;
    end
  end

  // Next state
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start_i && method_ok(method_i))
        begin
          state_nxt = ST_SEEK;
        end
      end
      ST_SEEK:
      begin
        if (edge_hit(seek_edge_r, home_rise, home_fall))
        begin
          state_nxt = mid_used_r ? ST_MID : ST_FINAL;
        end
      end
      ST_MID:
      begin
        if (home_fall)
        begin
          state_nxt = ST_FINAL;
        end
      end
      ST_FINAL:
      begin
        if (edge_hit(final_edge_r, home_rise, home_fall))
        begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE:
      begin
        if (start_i)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Phase programming and motion outputs
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r      <= ST_IDLE;
      method_r     <= 8'h00;
      start_on_r   <= 1'b0;
      limit_hit_r  <= 1'b0;
      seek_edge_r  <= `HM_EDGE_RISE;
      final_edge_r <= `HM_EDGE_FALL;
      mid_used_r   <= 1'b0;
      run_o        <= 1'b0;
      dir_fwd_o    <= `HM_DIR_FWD;
      speed_high_o <= `HM_SPD_LOW;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      error_o      <= 1'b0;
      zero_pos_o   <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      case (state_r)
        ST_IDLE:
        begin
          run_o <= 1'b0;
          busy_o <= 1'b0;
          if (start_i)
          begin
            error_o <= ~method_ok(method_i);
            done_o  <= 1'b0;
          end
          if (start_i && method_ok(method_i))
          begin
            method_r    <= method_i;
            start_on_r  <= home_s;
            limit_hit_r <= 1'b0;
            mid_used_r  <= 1'b0;
            busy_o      <= 1'b1;
            run_o       <= 1'b1;
            if (home_s)
            begin
              // Branch with switch already active
              case (method_i)
                `HM_M19, `HM_M23:
                begin
                  dir_fwd_o    <= `HM_DIR_REV;
                  speed_high_o <= `HM_SPD_LOW;
                  seek_edge_r  <= `HM_EDGE_FALL;
                  final_edge_r <= `HM_EDGE_FALL;
                end
                `HM_M20:
                begin
                  dir_fwd_o    <= `HM_DIR_REV;
                  speed_high_o <= `HM_SPD_HIGH;
                  seek_edge_r  <= `HM_EDGE_FALL;
                  final_edge_r <= `HM_EDGE_RISE;
                end
                `HM_M21:
                begin
                  dir_fwd_o    <= `HM_DIR_FWD;
                  speed_high_o <= `HM_SPD_LOW;
                  seek_edge_r  <= `HM_EDGE_FALL;
                  final_edge_r <= `HM_EDGE_FALL;
                end
                `HM_M22:
                begin
                  dir_fwd_o    <= `HM_DIR_FWD;
                  speed_high_o <= `HM_SPD_HIGH;
                  seek_edge_r  <= `HM_EDGE_FALL;
                  final_edge_r <= `HM_EDGE_RISE;
                end
                `HM_M24:
                begin
                  dir_fwd_o    <= `HM_DIR_REV;
                  speed_high_o <= `HM_SPD_LOW;
                  seek_edge_r  <= `HM_EDGE_FALL;
                  final_edge_r <= `HM_EDGE_RISE;
                end
                default:
                begin
                  dir_fwd_o    <= `HM_DIR_FWD;
                  speed_high_o <= `HM_SPD_LOW;
                  seek_edge_r  <= `HM_EDGE_FALL;
                  final_edge_r <= `HM_EDGE_RISE;
                end
              endcase
            end
            else
            begin
              // Search branch with switch inactive
              seek_edge_r  <= `HM_EDGE_RISE;
              speed_high_o <= `HM_SPD_HIGH;
              case (method_i)
                `HM_M20:
                begin
                  dir_fwd_o    <= `HM_DIR_FWD;
                  speed_high_o <= `HM_SPD_LOW;
                  final_edge_r <= `HM_EDGE_RISE;
                end
                `HM_M21:
                begin
                  dir_fwd_o    <= `HM_DIR_REV;
                  final_edge_r <= `HM_EDGE_FALL;
                end
                `HM_M22:
                begin
                  dir_fwd_o    <= `HM_DIR_REV;
                  speed_high_o <= `HM_SPD_LOW;
                  final_edge_r <= `HM_EDGE_RISE;
                end
                `HM_M24, `HM_M25:
                begin
                  dir_fwd_o    <= `HM_DIR_FWD;
                  final_edge_r <= `HM_EDGE_RISE;
                end
                default:
                begin
                  dir_fwd_o    <= `HM_DIR_FWD;
                  final_edge_r <= `HM_EDGE_FALL;
                end
              endcase
            end
          end
        end
        ST_SEEK:
        begin
          // Forward limit in search turns methods 23 to 25 started off the switch round at high speed
          if (lim_rise && !start_on_r && dir_fwd_o &&
              method_r >= `HM_M23)
          begin
            limit_hit_r  <= 1'b1;
            dir_fwd_o    <= `HM_DIR_REV;
            speed_high_o <= `HM_SPD_HIGH;
          end
          else if (state_nxt != ST_SEEK)
          begin
            // Low-speed start paths latch on the seek edge itself, except methods 24 and 25 started on the switch
            if (!speed_high_o && !start_on_r)
            begin
              zero_pos_o <= position_i;
              run_o      <= 1'b0;
              done_o     <= 1'b1;
              busy_o     <= 1'b0;
              state_r    <= ST_DONE;
            end
            else if (!speed_high_o && (method_r == `HM_M19 ||
                     method_r == `HM_M21 || method_r == `HM_M23))
            begin
              zero_pos_o <= position_i;
              run_o      <= 1'b0;
              done_o     <= 1'b1;
              busy_o     <= 1'b0;
              state_r    <= ST_DONE;
            end
            else
            begin
              speed_high_o <= `HM_SPD_LOW;
              if (limit_hit_r && method_r == `HM_M25)
              begin
                dir_fwd_o  <= `HM_DIR_FWD;
                mid_used_r <= 1'b1;
                state_r    <= ST_MID;
              end
              else if (limit_hit_r)
              begin
                dir_fwd_o <= `HM_DIR_REV;
                state_r   <= ST_FINAL;
              end
              else if (method_r == `HM_M25 && !start_on_r)
              begin
                dir_fwd_o <= `HM_DIR_FWD;
                state_r   <= ST_FINAL;
              end
              else
              begin
                dir_fwd_o <= ~dir_fwd_o;
                state_r   <= ST_FINAL;
              end
            end
          end
        end
        ST_MID:
        begin
          if (home_fall)
          begin
            dir_fwd_o <= `HM_DIR_REV;
          end
        end
        ST_FINAL:
        begin
          if (state_nxt == ST_DONE)
          begin
            zero_pos_o <= position_i;
            run_o      <= 1'b0;
            done_o     <= 1'b1;
            busy_o     <= 1'b0;
          end
        end
        ST_DONE:
        begin
          run_o <= 1'b0;
        end
        default:
        begin
          run_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: testbench/homing_seq_properties.sv
/*
  Port checker for the home-switch homing sequencer.
  Assumes a bind to the sequencer top and one clock domain.
*/
module homing_seq_properties (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        start_i,
  input wire logic [7:0]  method_i,
  input wire logic        home_sw_i,
  input wire logic        fwd_limit_i,
  input wire logic [31:0] position_i,
  input wire logic        run_o,
  input wire logic        dir_fwd_o,
  input wire logic        speed_high_o,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        error_o,
  input wire logic [31:0] zero_pos_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Start acceptance and expected first motion phase
  wire take  = start_i && !busy_o && !done_o && !error_o;
  wire ok_m  = method_i >= 8'h13 && method_i <= 8'h19;
  wire hi_on = method_i == 8'h14 || method_i == 8'h16;
  wire fw_on = method_i == 8'h15 || method_i == 8'h16 || method_i == 8'h19;
  wire fw_of = method_i == 8'h13 || method_i >= 8'h17;
  wire e_spd = home_sw_i ? hi_on : !(method_i == 8'h14 || method_i == 8'h16);
  wire e_dir = home_sw_i ? fw_on : fw_of;
  wire d_chk = home_sw_i || method_i != 8'h14;
  start_run_a: assert property (take && ok_m |=> run_o && busy_o)
    else $error("accepted start gave no motion");
  bad_method_a: assert property (take && !ok_m |=> error_o && !run_o)
    else $error("unsupported method not refused");
  first_speed_a: assert property (take && ok_m && $stable(home_sw_i)
    && home_sw_i == $past(home_sw_i, 2) |=> speed_high_o == $past(e_spd))
    else $error("wrong first speed");
  first_dir_a: assert property (take && ok_m && d_chk
    && $stable(home_sw_i) && home_sw_i == $past(home_sw_i, 2)
    |=> dir_fwd_o == $past(e_dir))
    else $error("wrong first direction");
  done_still_a: assert property (done_o |-> !run_o && !busy_o)
    else $error("motion while done");
  run_busy_a: assert property (run_o |-> busy_o)
    else $error("motion without busy");
  run_stop_a: assert property ($fell(run_o) |-> done_o)
    else $error("motion stopped without latch");
  zero_hold_a: assert property (done_o && $past(done_o)
    |-> $stable(zero_pos_o))
    else $error("zero position moved while done");
  err_still_a: assert property (error_o |-> !run_o && !busy_o)
    else $error("motion with error");
endmodule

bind home_switch_homing_sequencer homing_seq_properties chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(start_i),
  .method_i(method_i), .home_sw_i(home_sw_i), .fwd_limit_i(fwd_limit_i),
  .position_i(position_i), .run_o(run_o), .dir_fwd_o(dir_fwd_o),
  .speed_high_o(speed_high_o), .busy_o(busy_o), .done_o(done_o),
  .error_o(error_o), .zero_pos_o(zero_pos_o));

// file: testbench/motor_switch_model.sv
/*
  Motor, home switch and forward limit model for the homing bench.
  Assumes run, direction and speed come from the sequencer.
*/
module motor_switch_model (
  input  wire logic        mclk_i,
  input  wire logic        run_i,
  input  wire logic        dir_fwd_i,
  input  wire logic        speed_high_i,
  input  wire logic        load_i,
  input  wire logic [31:0] load_pos_i,
  input  wire logic        lim_en_i,
  output logic      [31:0] pos_o,
  output logic             home_o,
  output logic             limit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [31:0] step = speed_high_i ? 32'h4 : 32'h1;
  // Travel: four counts a cycle at high speed, one at low
  always @(posedge mclk_i)
  begin
    if (load_i)
      pos_o <= load_pos_i;
    else if (run_i)
      pos_o <= dir_fwd_i ? pos_o + step : pos_o - step;
  end
  // Home cams repeat every 300 counts; limit sits at 1250 when fitted
  assign home_o  = (pos_o % 300) >= 100 && (pos_o % 300) < 200;
  assign limit_o = lim_en_i && pos_o >= 32'd1250;
endmodule

// file: testbench/home_switch_homing_sequencer_tb.sv
/*
  Self-checking bench for the homing sequencer, driving it with a
  motor model. Assumes a 40 MHz clock and outputs settled 2 ns late.
*/
module home_switch_homing_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0;
  logic        resetn_i = 0;
  logic        start_i = 0;
  logic        load = 1;
  logic        lim_en = 0;
  logic [7:0]  method_i = 8'h13;
  logic [31:0] load_pos = 32'd900;
  wire  [31:0] pos, zero_pos_o;
  wire         home, limit, run_o, dir_fwd_o, speed_high_o;
  wire         busy_o, done_o, error_o;
  int          err_total = 0;
  int          check_count = 0;

  always #12.5 mclk_i = ~mclk_i;

  home_switch_homing_sequencer dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .start_i(start_i), .method_i(method_i), .home_sw_i(home),
    .fwd_limit_i(limit), .position_i(pos), .run_o(run_o),
    .dir_fwd_o(dir_fwd_o), .speed_high_o(speed_high_o), .busy_o(busy_o),
    .done_o(done_o), .error_o(error_o), .zero_pos_o(zero_pos_o));
  motor_switch_model motor (.mclk_i(mclk_i), .run_i(run_o),
    .dir_fwd_i(dir_fwd_o), .speed_high_i(speed_high_o), .load_i(load),
    .load_pos_i(load_pos), .lim_en_i(lim_en), .pos_o(pos), .home_o(home),
    .limit_o(limit));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic bit near(input logic [31:0] z, input logic [31:0] e);
    return (z - e < 32'd40) || (e - z < 32'd40);
  endfunction

  // Reset for 3 cycles with the motor parked, then let synchronisers fill
  task automatic prep(input logic [7:0] m, input logic [31:0] p, input l);
    resetn_i = 0;
    load = 1;
    load_pos = p;
    lim_en = l;
    method_i = m;
    repeat (3) @(posedge mclk_i);
    #2 resetn_i = 1;
    load = 0;
    repeat (4) @(posedge mclk_i);
    #2 start_i = 1;
    @(posedge mclk_i);
    #2 start_i = 0;
  endtask

  // Wait for the latch, judged on completion and latched zero position
  task automatic wait_zero(input logic [7:0] m, input logic [31:0] e,
                           input logic [31:0] a);
    int n;
    n = 0;
    while (done_o !== 1'b1 && n < 4000)
    begin
      @(posedge mclk_i);
      #2 n++;
    end
    check_count++;
    if (done_o !== 1'b1 ||
        !(near(zero_pos_o, e) || near(zero_pos_o, a)))
    begin
      err_total++;
      $display("unexpected at %0t: method %0d zero %0d", $time, m, zero_pos_o);
    end
    if (n >= 4000)
      end_sim();
  endtask

  // One homing run from reset
  task automatic home_run(input logic [7:0] m, input logic [31:0] p,
                          input l, input logic [31:0] e, input logic [31:0] a);
    prep(m, p, l);
    wait_zero(m, e, a);
  endtask

  // Asynchronous reset clears the outputs, except dir_fwd_o set forward, before the next clock edge
  task automatic reset_check();
    @(posedge mclk_i);
    #2 resetn_i = 0;
    #1 check_count++;
    if ({run_o, dir_fwd_o, speed_high_o, done_o} !== 4'h4 ||
        busy_o !== 1'b0 || error_o !== 1'b0 || zero_pos_o !== 32'h0)
    begin
      err_total++;
      $display("unexpected at %0t: reset outputs", $time);
    end
    @(posedge mclk_i);
    #2;
  endtask

  // Unsupported methods refused without motion, then reset values
  task automatic test_bad();
    logic [7:0] bad [2] = '{8'h12, 8'h1a};
    foreach (bad[i])
    begin
      prep(bad[i], 32'd900, 1'b0);
      @(posedge mclk_i);
      #2 check_count++;
      if (error_o !== 1'b1 || run_o !== 1'b0 || busy_o !== 1'b0)
      begin
        err_total++;
        $display("unexpected at %0t: method %0d accepted", $time, bad[i]);
      end
    end
    reset_check();
    $display("bad method test done");
  endtask

  task automatic test_off();
    home_run(8'h13, 900, 0, 1000, 1000);
    home_run(8'h14, 900, 0, 1000, 800);
    home_run(8'h15, 900, 0, 800, 800);
    home_run(8'h16, 900, 0, 800, 800);
    home_run(8'h17, 900, 0, 1000, 1000);
    home_run(8'h18, 900, 0, 800, 800);
    home_run(8'h19, 900, 0, 1300, 1000);
    $display("switch-off start test done");
  endtask

  task automatic test_on();
    home_run(8'h13, 1050, 0, 1000, 1000);
    home_run(8'h14, 1050, 0, 1000, 1000);
    home_run(8'h15, 1050, 0, 1100, 1100);
    home_run(8'h16, 1050, 0, 1100, 1100);
    home_run(8'h17, 1050, 0, 1000, 1000);
    home_run(8'h18, 1050, 0, 1000, 1000);
    home_run(8'h19, 1050, 0, 1100, 1100);
    $display("switch-on start test done");
  endtask

  task automatic test_limit();
    home_run(8'h17, 1150, 1, 1000, 1000);
    home_run(8'h18, 1150, 1, 800, 1100);
    home_run(8'h19, 1150, 1, 1100, 1100);
    home_run(8'h13, 1150, 1, 1300, 1300);
    $display("forward limit test done");
  endtask

  // Restart from the finished state; a start while busy is ignored
  task automatic test_again();
    home_run(8'h13, 900, 0, 1000, 1000);
    start_i = 1;
    @(posedge mclk_i);
    #2 start_i = 0;
    method_i = 8'h16;
    @(posedge mclk_i);
    #2 start_i = 1;
    @(posedge mclk_i);
    #2 start_i = 0;
    check_count++;
    if (done_o !== 1'b0 || busy_o !== 1'b1 || speed_high_o !== 1'b0)
    begin
      err_total++;
      $display("unexpected at %0t: restart not taken", $time);
    end
    @(posedge mclk_i);
    #2 start_i = 1;
    method_i = 8'h12;
    @(posedge mclk_i);
    #2 start_i = 0;
    method_i = 8'h16;
    check_count++;
    if (error_o !== 1'b0 || busy_o !== 1'b1)
    begin
      err_total++;
      $display("unexpected at %0t: start while busy acted", $time);
    end
    wait_zero(8'h16, 800, 800);
    reset_check();
    $display("restart test done");
  endtask

  initial
  begin
    test_bad();
    test_off();
    test_on();
    test_limit();
    test_again();
    end_sim();
  end
endmodule
